// File: usfp_port.v
`timescale 1ns/1ns
`include "usfp_regs.vh"
// Function
// - port runs only with parallel-fifo configuration and sync mode command given.
// - every bus transfer happens on a rising edge of the interface clock.
// - device drives the interface clock; far side is synchronous to it.
// - data bus is input; driven only while output enable is low.
// - receive flag high when no byte buffered or outside sync mode, low otherwise.
// - one byte read per edge where receive flag and read strobe are low.
// - transmit flag high when buffer full, low when writing allowed.
// - one byte written per edge where transmit flag and write strobe low.
// - falling read strobe shows current byte, then advances each cycle.
// - low write strobe captures a bus byte each cycle until released.
// - wake pulse while suspended with wakeup enabled requests usb resume.
// - wake pulse in normal operation flushes all transmit data next bulk-in.
module usfp_port #(
    parameter AW = 9
) (
    input  wire       clk_sys,          // system clock
    input  wire       nrst,             // async reset, low
    input  wire       cfg_fifo_mode,    // config memory selects parallel fifo
    input  wire       mode_cmd_valid,   // mode select command pulse
    input  wire [7:0] mode_cmd_code,    // mode select command code
    input  wire       cfg_remote_wake,  // remote wakeup enabled in config
    input  wire       usb_suspended,    // bus suspended
    output reg        interface_clock,  // clock to far side
    input  wire [7:0] fifo_data_bus_i,  // data bus in
    output reg  [7:0] fifo_data_bus_o,  // data bus out
    output reg        fifo_data_bus_oe, // data bus drive enable
    input  wire       rd_n,             // read strobe, low
    input  wire       wr_n,             // write strobe, low
    input  wire       oe_n,             // output enable, low
    input  wire       flush_or_wake_n,  // send-immediate / wake, low
    output reg        rx_available_n,   // receive data flag, low
    output reg        tx_space_n,       // transmit space flag, low
    output reg        bus_active_n,     // low in normal operation
    input  wire       usb_rx_valid,     // byte from usb into receive buffer
    input  wire [7:0] usb_rx_data,      // that byte
    output reg        usb_rx_ready,     // receive buffer has room
    input  wire       usb_tx_ready,     // usb side takes a transmit byte
    output reg        usb_tx_valid,     // transmit byte available
    output reg  [7:0] usb_tx_data,      // transmit byte
    output reg        usb_send_now,     // flush pending data on next bulk-in, pulse
    output reg        usb_resume_req,   // resume request, pulse
    output reg        sync_mode_active  // sync fifo mode entered
);
    // =====================================================
    // mode entry
    reg  sync_nxt;
    always @* begin
        sync_nxt = sync_mode_active;
        if (!cfg_fifo_mode) begin
            sync_nxt = 1'b0;
        end else if (mode_cmd_valid) begin
            sync_nxt = (mode_cmd_code == `USFP_MODE_SYNC_FIFO);
        end
    end

    // =====================================================
    // interface clock; read and write strobes are sampled on its rising edge only
    reg  [3:0] div_r;
    wire       if_rise = (div_r == `USFP_IFCLK_HALF - 1) && !interface_clock;

    // =====================================================
    // buffers
    wire       rxq_empty;
    wire       rxq_full;
    wire [7:0] rxq_head;
    wire       txq_empty;
    wire       txq_full;
    wire [7:0] txq_head;
    wire       rd_take = sync_mode_active & if_rise & ~rd_n & ~rx_available_n;
    wire       wr_take = sync_mode_active & if_rise & ~wr_n & ~tx_space_n;
    wire       usb_tx_take = usb_tx_valid & usb_tx_ready;

    usfp_mem #(.DW(8), .AW(AW)) u_rxq (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .wr_en   (usb_rx_valid),
        .wr_data (usb_rx_data),
        .rd_en   (rd_take),
        .rd_data (rxq_head),
        .empty   (rxq_empty),
        .full    (rxq_full)
    );

    usfp_mem #(.DW(8), .AW(AW)) u_txq (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .wr_en   (wr_take),
        .wr_data (fifo_data_bus_i),
        .rd_en   (usb_tx_take),
        .rd_data (txq_head),
        .empty   (txq_empty),
        .full    (txq_full)
    );

    // =====================================================
    // wake / send-immediate strobe, acted on at its falling edge
    reg  fw_prev_r;
    wire fw_fall = fw_prev_r & ~flush_or_wake_n;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_mode_active <= 1'b0;
            div_r            <= 4'h0;
            interface_clock  <= 1'b0;
            fifo_data_bus_o  <= `USFP_DATA_RST;
            fifo_data_bus_oe <= 1'b0;
            rx_available_n   <= 1'b1;
            tx_space_n       <= 1'b1;
            bus_active_n     <= 1'b1;
            usb_rx_ready     <= 1'b0;
            usb_tx_valid     <= 1'b0;
            usb_tx_data      <= `USFP_DATA_RST;
            usb_send_now     <= 1'b0;
            usb_resume_req   <= 1'b0;
            fw_prev_r        <= 1'b1;
        end else begin
            sync_mode_active <= sync_nxt;
            if (div_r == `USFP_IFCLK_HALF - 1) begin
                div_r           <= 4'h0;
                interface_clock <= ~interface_clock;
            end else begin
                div_r <= div_r + 4'h1;
            end
            // flags follow buffer state; held high outside sync mode
            rx_available_n   <= ~sync_nxt | rxq_empty;
            tx_space_n       <= ~sync_nxt | txq_full;
            fifo_data_bus_o  <= rxq_head;
            fifo_data_bus_oe <= sync_nxt & ~oe_n;
            bus_active_n     <= usb_suspended;
            usb_rx_ready     <= ~rxq_full;
            usb_tx_valid     <= ~txq_empty & ~usb_tx_take;
            usb_tx_data      <= txq_head;
            fw_prev_r        <= flush_or_wake_n;
            usb_resume_req   <= fw_fall & usb_suspended & cfg_remote_wake;
            usb_send_now     <= fw_fall & ~usb_suspended & sync_mode_active;
        end
    end
endmodule

// File: usfp_regs.vh
`ifndef USFP_REGS_VH
`define USFP_REGS_VH

// =====================================================
// timing
`define USFP_CLK_SYS_HZ      10000000
`define USFP_IFCLK_HZ        60000000
// clk_sys cycles per half period of the interface clock (divide ratio is twice this), at least one
`define USFP_IFCLK_HALF      1
// =====================================================
// mode select codes
`define USFP_MODE_W          8
`define USFP_MODE_SYNC_FIFO  8'h40
// =====================================================
// reset values
`define USFP_DATA_RST        8'h00

`endif

// File: usfp_mem.v
`timescale 1ns/1ns
// =====================================================
// byte ring buffer, registered read data
module usfp_mem #(
    parameter DW = 8,
    parameter AW = 9
) (
    input  wire          clk_sys,  // clock
    input  wire          nrst,     // async reset, low
    input  wire          wr_en,    // push
    input  wire [DW-1:0] wr_data,  // push data
    input  wire          rd_en,    // pop
    output reg  [DW-1:0] rd_data,  // head byte, registered
    output reg           empty,    // no byte stored
    output reg           full      // no room
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [AW:0]   wp_r;
    reg [AW:0]   rp_r;
    wire         do_wr = wr_en & ~full;
    wire         do_rd = rd_en & ~empty;
    wire [AW:0]  wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
    wire [AW:0]  rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;

    always @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wp_r[AW-1:0]] <= wr_data;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wp_r    <= {(AW+1){1'b0}};
            rp_r    <= {(AW+1){1'b0}};
            empty   <= 1'b1;
            full    <= 1'b0;
            rd_data <= {DW{1'b0}};
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            empty <= (wp_nxt == rp_nxt);
            full  <= (wp_nxt[AW] != rp_nxt[AW]) && (wp_nxt[AW-1:0] == rp_nxt[AW-1:0]);
            // show-ahead: head after the update; bypass when writing into an empty slot
            if (do_wr && (wp_r[AW-1:0] == rp_nxt[AW-1:0])) begin
                rd_data <= wr_data;
            end else begin
                rd_data <= mem[rp_nxt[AW-1:0]];
            end
        end
    end
endmodule

// File: usfp_port_chk.sv
`timescale 1ns/1ns
// ========================================
// port checker
module usfp_port_chk (
    input wire       clk_sys, nrst, cfg_fifo_mode, mode_cmd_valid, cfg_remote_wake,
    input wire       usb_suspended, interface_clock, oe_n, flush_or_wake_n,
    input wire       fifo_data_bus_oe, usb_send_now, usb_resume_req, sync_mode_active,
    input wire       rx_available_n, tx_space_n, bus_active_n,
    input wire [7:0] mode_cmd_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_ifclk_toggle: assert property (1 |=> interface_clock != $past(interface_clock))
        else $error("interface clock stuck");
    a_bus_quiet: assert property (fifo_data_bus_oe |-> !$past(oe_n))
        else $error("bus driven without enable");
    a_bus_drive: assert property (!oe_n && sync_mode_active && cfg_fifo_mode && !mode_cmd_valid
        |=> fifo_data_bus_oe) else $error("bus not driven");
    a_bus_release: assert property (oe_n |=> !fifo_data_bus_oe)
        else $error("bus driven after enable released");
    a_flags_idle: assert property (!cfg_fifo_mode |=> rx_available_n && tx_space_n)
        else $error("flag low outside sync mode");
    a_suspend_flag: assert property (1 |=> bus_active_n == $past(usb_suspended))
        else $error("bus active flag wrong");
    a_wake_resume: assert property ($fell(flush_or_wake_n) && usb_suspended && cfg_remote_wake
        |=> usb_resume_req) else $error("no resume request");
    a_wake_flush: assert property ($fell(flush_or_wake_n) && !usb_suspended && sync_mode_active
        |=> usb_send_now) else $error("no flush");
    a_flush_cause: assert property (usb_send_now |-> $past(flush_or_wake_n, 2)
        && !$past(flush_or_wake_n)) else $error("flush without strobe");
    a_mode_enter: assert property (cfg_fifo_mode && mode_cmd_valid && mode_cmd_code == 8'h40
        |=> sync_mode_active) else $error("mode not entered");
    a_mode_drop: assert property (!cfg_fifo_mode |=> !sync_mode_active)
        else $error("mode kept without config");
    a_mode_reject: assert property (mode_cmd_valid && mode_cmd_code != 8'h40
        |=> !sync_mode_active) else $error("wrong code accepted");
    c_resume: cover property ($fell(flush_or_wake_n) && usb_suspended && cfg_remote_wake);
    c_flush: cover property (usb_send_now);
    c_read: cover property (fifo_data_bus_oe && !oe_n);
endmodule

bind usfp_port usfp_port_chk i_usfp_port_chk (.*);

// File: usfp_host.sv
`timescale 1ns/1ns
// ========================================
// fifo master, moves only after an interface clock rise
module usfp_host (
    input  wire       clk_sys, interface_clock, rd_go, wr_go,
    output reg        oe_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1,
    output reg  [7:0] dout = 8'h00
);
    always @(negedge clk_sys)
        if (interface_clock) begin
            oe_n <= !rd_go;
            rd_n <= !(rd_go && !oe_n);
            wr_n <= !(wr_go && oe_n);
            dout <= dout + 8'h01;
        end
endmodule

// File: test_usfp_port.sv
`timescale 1ns/1ns
// ========================================
// random traffic against queue model
module test_usfp_port;
    reg         clk_sys = 0, nrst = 0, cfg_fifo_mode = 0, mode_cmd_valid = 0, mode = 0;
    reg         cfg_remote_wake = 0, usb_suspended = 0, flush_or_wake_n = 1, rd_go = 0;
    reg         usb_rx_valid = 0, usb_tx_ready = 0, wr_go = 0;
    reg   [7:0] mode_cmd_code = 8'h00, usb_rx_data = 8'h00, rq[$], tq[$];
    reg  [31:0] seed = 32'h2f815c27;
    wire        interface_clock, fifo_data_bus_oe, rd_n, wr_n, oe_n, rx_available_n;
    wire        tx_space_n, usb_rx_ready, usb_tx_valid, sync_mode_active;
    wire  [7:0] fifo_data_bus_o, usb_tx_data, dout;
    wire  [7:0] bus = fifo_data_bus_oe ? fifo_data_bus_o : dout;
    integer     n_mismatch = 0, compares = 0, cyc = 0, i, sz;
    usfp_port #(.AW(3)) i_usfp_port (.*, .fifo_data_bus_i(bus), .bus_active_n(),
        .usb_send_now(), .usb_resume_req());
    usfp_host i_usfp_host (.*);
    always #50 clk_sys = !clk_sys;
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task step(input integer n);
        repeat (n) begin
            @(negedge clk_sys);
            seed = xs(seed);
            usb_rx_valid = rd_go && usb_rx_ready && seed[1:0] == 2'b00;
            usb_rx_data = seed[15:8];
            usb_tx_ready = seed[20] && seed[21];
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    // ========================================
    // queue model, bus transfers on interface clock rise only, usb side transfers on any clk_sys rise
    always @(posedge clk_sys) if (nrst) begin
        // the buffer refuses a push by its fill level before this edge's pop
        sz = rq.size();
        if (mode && !interface_clock && !rd_n && !rx_available_n)
            chk("rd", fifo_data_bus_o, rq.pop_front());
        if (usb_tx_valid && usb_tx_ready)
            chk("tx", usb_tx_data, tq.pop_front());
        if (mode && !interface_clock && !wr_n && !tx_space_n) tq.push_back(bus);
        if (usb_rx_valid && sz < 8) rq.push_back(usb_rx_data);
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        nrst = 1;
        step(2);
        cfg_fifo_mode = 1;
        mode_cmd_valid = 1;
        mode_cmd_code = 8'h41;
        wr_go <= 1;
        step(1);
        mode_cmd_valid = 0;
        step(12);
        chk("refused", {7'h00, sync_mode_active}, 8'h00);
        mode_cmd_code = 8'h40;
        mode_cmd_valid = 1;
        step(1);
        mode_cmd_valid = 0;
        mode = 1;
        for (i = 0; i < 4; i = i + 1) begin
            usb_suspended = i[0];
            cfg_remote_wake = i[1];
            {rd_go, wr_go} <= 2'b01;
            step(40);
            {rd_go, wr_go} <= 2'b10;
            flush_or_wake_n = 0;
            step(1);
            flush_or_wake_n = 1;
            step(40);
        end
        {rd_go, wr_go} <= 2'b00;
        step(4);
        repeat (40) @(negedge clk_sys) usb_tx_ready = 1;
        chk("drain", 8'(tq.size()), 8'h00);
        cfg_fifo_mode = 0;
        step(2);
        chk("drop", {7'h00, sync_mode_active}, 8'h00);
        wrap_up;
    end
endmodule
